/* File: rtl/exec_alu.sv */
// arithmetic and logic for subtract and exclusive-or
`timescale 1ns/1ps
`default_nettype none
module exec_alu
(
	input  var  core_pkg::op_type op_in,
	input  wire logic [7:0]       work_in,
	input  wire logic [7:0]       imm_in,
	input  wire logic [7:0]       file_in,
	output logic      [7:0]       res_out,
	output logic                  carry_out,
	output logic                  nib_out,
	output logic                  zero_out
);
	logic [8:0] sub9;
	logic [4:0] nib5;

	// two's complement imm minus work, carry means no borrow
	always_comb
	begin
		sub9 = {1'b0, imm_in} + {1'b0, ~work_in} + 9'h001;
		nib5 = {1'b0, imm_in[3:0]} + {1'b0, ~work_in[3:0]} + 5'h01;
		if (op_in == core_pkg::OP_IMM_MINUS_WORK)
			res_out = sub9[7:0];
		else if (op_in == core_pkg::OP_XOR_FILE)
			res_out = work_in ^ file_in;
		else
			res_out = work_in ^ imm_in;
		carry_out = sub9[8];
		nib_out   = nib5[4];
		zero_out  = (res_out == 8'h00);
	end
endmodule
`default_nettype wire

/* File: rtl/exec_core.sv */
// instruction execution unit with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module exec_core
(
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	output logic      [10:0] ROM_ADDR_OUT,
	output logic             ROM_RD_OUT,
	input  wire logic [13:0] ROM_DATA_IN,
	output logic      [7:0]  TIMER0_MODE_OUT
);
	core_pkg::state_type st_r;
	core_pkg::state_type st_nxt;
	core_pkg::op_type    op_r;
	logic                dp_r;
	logic                dp_wr_r;
	logic [7:0]          dp_addr_r;
	logic [7:0]          work_r;
	logic                carry_r;
	logic                nib_r;
	logic                zero_r;
	logic [2:0]          tph_r;
	logic [5:0]          tdh_r;
	logic [7:0]          t0m_r;
	logic [5:0]          fsel_r;
	logic [7:0]          imm_r;
	logic [5:0]          faddr_r;
	logic                dest_r;
	logic [31:0]         hrdata_r;
	logic                hready_r;
	logic                hresp_r;
	logic [10:0]         rom_addr_r;
	logic                rom_rd_r;
	logic                acc;
	logic                wr_now;
	logic                launch;
	logic                exec;
	logic                mem_we;
	logic [5:0]          mem_waddr;
	logic [7:0]          mem_wdata;
	logic [5:0]          mem_raddr;
	logic [7:0]          mem_rdata;
	logic [7:0]          alu_res;
	logic                alu_c;
	logic                alu_dc;
	logic                alu_z;
	logic [7:0]          rom_lo;
	logic [5:0]          rom_hi;

	// word-aligned register hit
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a[7:2] == off[7:2];
	endfunction

	// bus phase qualifiers
	assign acc    = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	assign wr_now = dp_r & dp_wr_r & HREADY_IN;
	assign launch = wr_now & hit(dp_addr_r, core_pkg::REG_CMD);
	assign exec   = (st_r == core_pkg::S_EXEC);
	assign rom_lo = ROM_DATA_IN[7:0];
	assign rom_hi = ROM_DATA_IN[13:8];

	// address phase capture
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
		begin
			dp_r      <= 1'b0;
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 8'h00;
		end
		else if (HREADY_IN)
		begin
			dp_r      <= acc;
			dp_wr_r   <= HWRITE_IN;
			dp_addr_r <= HADDR_IN[7:0];
		end
	end

	// sequencer next state
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			core_pkg::S_IDLE:
			begin
				if (launch)
				begin
					if (HWDATA_IN[2:0] == core_pkg::OP_TABLE_READ)
						st_nxt = core_pkg::S_TBL1;
					else
						st_nxt = core_pkg::S_EXEC;
				end
				else if (acc && !HWRITE_IN)
					st_nxt = core_pkg::S_RDW;
			end
			core_pkg::S_EXEC, core_pkg::S_TBL2:
			begin
				if (dp_r && !dp_wr_r)
					st_nxt = core_pkg::S_RDW;
				else
					st_nxt = core_pkg::S_IDLE;
			end
			core_pkg::S_TBL1: st_nxt = core_pkg::S_TBL2;
			core_pkg::S_RDW:  st_nxt = core_pkg::S_IDLE;
			default:          st_nxt = core_pkg::S_IDLE;
		endcase
	end

	// sequencer state and ready; stall while busy
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
		begin
			st_r     <= core_pkg::S_IDLE;
			hready_r <= 1'b1;
			hresp_r  <= 1'b0;
		end
		else
		begin
			st_r     <= st_nxt;
			hready_r <= (st_nxt == core_pkg::S_IDLE);
			hresp_r  <= 1'b0;
		end
	end

	// command latch on launch
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
		begin
			op_r    <= core_pkg::OP_NONE_A;
			imm_r   <= 8'h00;
			faddr_r <= 6'h00;
			dest_r  <= 1'b0;
		end
		else if (launch)
		begin
			op_r    <= core_pkg::op_type'(HWDATA_IN[core_pkg::CMD_OP_LSB +: 3]);
			imm_r   <= HWDATA_IN[core_pkg::CMD_IMM_LSB +: 8];
			faddr_r <= HWDATA_IN[core_pkg::CMD_FILE_LSB +: 6];
			dest_r  <= HWDATA_IN[core_pkg::CMD_DEST_BIT];
		end
	end

	// work register
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
			work_r <= core_pkg::WORK_RST;
		else if (wr_now && hit(dp_addr_r, core_pkg::REG_WORK))
			work_r <= HWDATA_IN[7:0];
		else if (exec)
		begin
			unique case (op_r)
				core_pkg::OP_IMM_MINUS_WORK: work_r <= alu_res;
				core_pkg::OP_TMODE_READ:     work_r <= t0m_r;
				core_pkg::OP_XOR_FILE:
				begin
					if (!dest_r)
						work_r <= alu_res;
				end
				core_pkg::OP_XOR_IMM:        work_r <= alu_res;
				default:                     work_r <= work_r;
			endcase
		end
		else if (st_r == core_pkg::S_TBL2)
			work_r <= rom_lo;
	end

	// status flags; load, read and table leave them alone
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
			{zero_r, nib_r, carry_r} <= core_pkg::FLAGS_RST;
		else if (wr_now && hit(dp_addr_r, core_pkg::REG_STATUS))
		begin
			carry_r <= HWDATA_IN[core_pkg::ST_CARRY];
			nib_r   <= HWDATA_IN[core_pkg::ST_NIB];
			zero_r  <= HWDATA_IN[core_pkg::ST_ZERO];
		end
		else if (exec && op_r == core_pkg::OP_IMM_MINUS_WORK)
		begin
			carry_r <= alu_c;
			nib_r   <= alu_dc;
			zero_r  <= alu_z;
		end
		else if (exec && (op_r == core_pkg::OP_XOR_FILE || op_r == core_pkg::OP_XOR_IMM))
			zero_r <= alu_z;
	end

	// table pointer, table data high, timer mode, file select
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
		begin
			tph_r  <= core_pkg::TPH_RST;
			tdh_r  <= core_pkg::TDH_RST;
			t0m_r  <= core_pkg::T0MODE_RST;
			fsel_r <= core_pkg::FSEL_RST;
		end
		else
		begin
			if (wr_now && hit(dp_addr_r, core_pkg::REG_TPH))
				tph_r <= HWDATA_IN[2:0];
			if (wr_now && hit(dp_addr_r, core_pkg::REG_FSEL))
				fsel_r <= HWDATA_IN[5:0];
			if (st_r == core_pkg::S_TBL2)
				tdh_r <= rom_hi;
			if (exec && op_r == core_pkg::OP_TMODE_LOAD)
				t0m_r <= work_r;
		end
	end

	// program memory request, address held over the table read
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
		begin
			rom_addr_r <= 11'h000;
			rom_rd_r   <= 1'b0;
		end
		else
		begin
			if (st_nxt == core_pkg::S_TBL1)
				rom_addr_r <= {tph_r, work_r};
			rom_rd_r <= (st_nxt == core_pkg::S_TBL1);
		end
	end

	// read data during the read wait cycle
	always_ff @(posedge SYS_CLK_IN)
	begin
		if (RST_IN)
			hrdata_r <= 32'h0000_0000;
		else if (st_r == core_pkg::S_RDW)
		begin
			hrdata_r <= 32'h0000_0000;
			if (hit(dp_addr_r, core_pkg::REG_CMD))
				hrdata_r <= {7'h00, dest_r, 2'h0, faddr_r, imm_r, 5'h00, op_r};
			if (hit(dp_addr_r, core_pkg::REG_WORK))
				hrdata_r <= {24'h000000, work_r};
			if (hit(dp_addr_r, core_pkg::REG_STATUS))
				hrdata_r <= {29'h00000000, zero_r, nib_r, carry_r};
			if (hit(dp_addr_r, core_pkg::REG_TPH))
				hrdata_r <= {29'h00000000, tph_r};
			if (hit(dp_addr_r, core_pkg::REG_TDH))
				hrdata_r <= {26'h0000000, tdh_r};
			if (hit(dp_addr_r, core_pkg::REG_T0MODE))
				hrdata_r <= {24'h000000, t0m_r};
			if (hit(dp_addr_r, core_pkg::REG_FSEL))
				hrdata_r <= {26'h0000000, fsel_r};
			if (hit(dp_addr_r, core_pkg::REG_FDATA))
				hrdata_r <= {24'h000000, mem_rdata};
		end
	end

	// file memory ports; operand fetched while the command is written
	always_comb
	begin
		if (launch)
			mem_raddr = HWDATA_IN[core_pkg::CMD_FILE_LSB +: 6];
		else if (wr_now && hit(dp_addr_r, core_pkg::REG_FSEL))
			mem_raddr = HWDATA_IN[5:0];
		else
			mem_raddr = fsel_r;
		mem_we    = (wr_now && hit(dp_addr_r, core_pkg::REG_FDATA))
			|| (exec && op_r == core_pkg::OP_XOR_FILE && dest_r);
		mem_waddr = exec ? faddr_r : fsel_r;
		mem_wdata = exec ? alu_res : HWDATA_IN[7:0];
	end

	file_mem u_mem
	(
		.clk_in    (SYS_CLK_IN),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (mem_raddr),
		.rdata_out (mem_rdata)
	);

	exec_alu u_alu
	(
		.op_in     (op_r),
		.work_in   (work_r),
		.imm_in    (imm_r),
		.file_in   (mem_rdata),
		.res_out   (alu_res),
		.carry_out (alu_c),
		.nib_out   (alu_dc),
		.zero_out  (alu_z)
	);

	// port drivers, all from flops
	assign HRDATA_OUT      = hrdata_r;
	assign HREADYOUT_OUT   = hready_r;
	assign HRESP_OUT       = hresp_r;
	assign ROM_ADDR_OUT    = rom_addr_r;
	assign ROM_RD_OUT      = rom_rd_r;
	assign TIMER0_MODE_OUT = t0m_r;

	// checks
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	AST_SUB_WORK: assert property (
		exec && op_r == core_pkg::OP_IMM_MINUS_WORK |=>
		work_r == 8'($past(imm_r) - $past(work_r)) && st_r != core_pkg::S_EXEC)
		else $error("subtract result wrong");
	AST_SUB_FLAGS: assert property (
		exec && op_r == core_pkg::OP_IMM_MINUS_WORK |=>
		carry_r == ($past(imm_r) >= $past(work_r))
		&& nib_r == ($past(imm_r[3:0]) >= $past(work_r[3:0])))
		else $error("subtract borrow flags wrong");
	AST_TBL_SEQ: assert property (
		launch && HWDATA_IN[2:0] == core_pkg::OP_TABLE_READ |=>
		st_r == core_pkg::S_TBL1 && ROM_RD_OUT
		&& ROM_ADDR_OUT == {tph_r, work_r} ##1 st_r == core_pkg::S_TBL2 ##1 hready_r || dp_r)
		else $error("table read sequence wrong");
	AST_TBL_LOW: assert property (
		st_r == core_pkg::S_TBL2 |=> work_r == $past(rom_lo))
		else $error("table low byte wrong");
	AST_TBL_HIGH: assert property (
		st_r == core_pkg::S_TBL2 |=> tdh_r == $past(rom_hi))
		else $error("table high bits wrong");
	AST_TMODE_LOAD: assert property (
		exec && op_r == core_pkg::OP_TMODE_LOAD |=> TIMER0_MODE_OUT == $past(work_r)
		&& $stable(carry_r) && $stable(nib_r) && $stable(zero_r))
		else $error("timer mode load wrong");
	AST_TMODE_READ: assert property (
		exec && op_r == core_pkg::OP_TMODE_READ |=> work_r == $past(t0m_r)
		&& $stable(carry_r) && $stable(nib_r) && $stable(zero_r))
		else $error("timer mode read wrong");
	AST_XOR_FILE: assert property (
		exec && op_r == core_pkg::OP_XOR_FILE && !dest_r |=>
		work_r == ($past(work_r) ^ $past(mem_rdata))
		&& zero_r == ($past(work_r) == $past(mem_rdata)) && $stable(carry_r))
		else $error("file xor to work wrong");
	AST_XOR_DEST: assert property (
		exec && op_r == core_pkg::OP_XOR_FILE && dest_r |->
		mem_we && mem_waddr == faddr_r ##1 $stable(work_r))
		else $error("file xor to file wrong");
	AST_XOR_IMM: assert property (
		exec && op_r == core_pkg::OP_XOR_IMM |=>
		work_r == ($past(work_r) ^ $past(imm_r)) && $stable(nib_r) && $stable(carry_r)
		&& zero_r == ($past(work_r) == $past(imm_r)))
		else $error("immediate xor wrong");

	COV_TBL: cover property (st_r == core_pkg::S_TBL1 ##1 st_r == core_pkg::S_TBL2);
	COV_SUB_BORROW: cover property (exec && op_r == core_pkg::OP_IMM_MINUS_WORK && !alu_c);
	COV_XOR_FILE: cover property (exec && op_r == core_pkg::OP_XOR_FILE && dest_r);
	COV_RD_STALL: cover property (exec ##1 st_r == core_pkg::S_RDW);
endmodule
`default_nettype wire

/* File: rtl/file_mem.sv */
// file register memory, registered read, write-through
`timescale 1ns/1ps
`default_nettype none
module file_mem
(
	input  wire logic       clk_in,
	input  wire logic       we_in,
	input  wire logic [5:0] waddr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic [5:0] raddr_in,
	output logic      [7:0] rdata_out
);
	logic [7:0] mem_r [0:63];
	logic [7:0] rdata_r;

	// storage write
	always_ff @(posedge clk_in)
	begin
		if (we_in)
			mem_r[waddr_in] <= wdata_in;
	end

	// read port, new data wins on same address
	always_ff @(posedge clk_in)
	begin
		if (we_in && (waddr_in == raddr_in))
			rdata_r <= wdata_in;
		else
			rdata_r <= mem_r[raddr_in];
	end

	assign rdata_out = rdata_r;
endmodule
`default_nettype wire

/* File: shared/core_pkg.sv */
// constants and types shared by the instruction execution unit
package core_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_WORK   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_TPH    = 8'h0C;
	localparam logic [7:0] REG_TDH    = 8'h10;
	localparam logic [7:0] REG_T0MODE = 8'h14;
	localparam logic [7:0] REG_FSEL   = 8'h18;
	localparam logic [7:0] REG_FDATA  = 8'h1C;
	// command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_IMM_LSB  = 8;
	localparam int CMD_FILE_LSB = 16;
	localparam int CMD_DEST_BIT = 24;
	// status bit positions
	localparam int ST_CARRY = 0;
	localparam int ST_NIB   = 1;
	localparam int ST_ZERO  = 2;
	// widths
	localparam int WORD_W  = 8;
	localparam int FILE_AW = 6;
	localparam int TPH_W   = 3;
	localparam int TDH_W   = 6;
	localparam int ROM_AW  = 11;
	localparam int ROM_DW  = 14;
	// reset values
	localparam logic [7:0] WORK_RST   = 8'h00;
	localparam logic [2:0] FLAGS_RST  = 3'h0;
	localparam logic [2:0] TPH_RST    = 3'h0;
	localparam logic [5:0] TDH_RST    = 6'h00;
	localparam logic [7:0] T0MODE_RST = 8'h00;
	localparam logic [5:0] FSEL_RST   = 6'h00;
	// instruction codes in the command word
	typedef enum logic [2:0] {
		OP_IMM_MINUS_WORK = 3'b000,
		OP_TABLE_READ     = 3'b001,
		OP_TMODE_LOAD     = 3'b010,
		OP_TMODE_READ     = 3'b011,
		OP_XOR_FILE       = 3'b100,
		OP_XOR_IMM        = 3'b101,
		OP_NONE_A         = 3'b110,
		OP_NONE_B         = 3'b111
	} op_type;
	// sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_EXEC = 3'b001,
		S_TBL1 = 3'b010,
		S_TBL2 = 3'b011,
		S_RDW  = 3'b100
	} state_type;
endpackage

/* File: testbench/tb_top.sv */
// self-checking bench for the instruction execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        sys_clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic [10:0] rom_addr;
	logic        rom_rd;
	logic [13:0] rom_q = 14'h0;
	logic [10:0] rom_seen = 11'h0;
	logic [7:0]  t0_mode;
	int          err_total;
	int          num_checks;
	int          low_cnt;
	int          base;
	int          i;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [7:0]  r;
	logic [13:0] w;
	logic [7:0]  sub_i [6] = '{8'h05, 8'h06, 8'h10, 8'h33, 8'h00, 8'hFF};
	logic [7:0]  sub_w [6] = '{8'h06, 8'h05, 8'h01, 8'h33, 8'hFF, 8'h00};
	logic [7:0]  tbl_p [3] = '{8'h02, 8'h07, 8'hF8};
	logic [7:0]  tbl_w [3] = '{8'h34, 8'hFF, 8'h00};

	exec_core dut
	(
		.SYS_CLK_IN      (sys_clk),
		.RST_IN          (rst),
		.HSEL_IN         (hsel),
		.HADDR_IN        (haddr),
		.HTRANS_IN       (htrans),
		.HWRITE_IN       (hwrite),
		.HSIZE_IN        (3'h2),
		.HWDATA_IN       (hwdata),
		.HREADY_IN       (hready),
		.HRDATA_OUT      (hrdata),
		.HREADYOUT_OUT   (hready),
		.HRESP_OUT       (hresp),
		.ROM_ADDR_OUT    (rom_addr),
		.ROM_RD_OUT      (rom_rd),
		.ROM_DATA_IN     (rom_q),
		.TIMER0_MODE_OUT (t0_mode)
	);

	// program word contents derived from the address
	function automatic logic [13:0] rom_word(input logic [10:0] ad);
		return {ad[10:5] ^ 6'h35, ad[7:0] ^ {ad[10:8], 5'h0A}};
	endfunction

	// synchronous program memory, one cycle latency, scrambled when idle
	always @(posedge sys_clk)
	begin
		if (rom_rd === 1'b1)
		begin
			rom_q    <= rom_word(rom_addr);
			rom_seen <= rom_addr;
		end
		else
			rom_q <= ~rom_q;
	end

	// cycles with the bus stalled
	always @(posedge sys_clk)
		if (hready !== 1'b1)
			low_cnt <= low_cnt + 1;

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// waits for hready high at a rising edge, bounded
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		if (n >= 64)
			chk({31'h0, hready}, 32'h1);
	endtask

	// one single AHB-Lite transfer, address phase then data phase
	task automatic xfer(input logic [7:0] ad, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, ad};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		logic [31:0] dummy;
		xfer(ad, 1'b1, wd, dummy);
	endtask

	task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
		logic [31:0] got;
		xfer(ad, 1'b0, 32'h0, got);
		chk(got, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// launches one instruction, then checks stall length, work and status
	task automatic run(input core_pkg::op_type op, input logic [7:0] imm,
		input logic [5:0] fa, input logic dest, input int busy,
		input logic [7:0] ew, input logic [31:0] es);
		logic [31:0] c;
		c = 32'h0;
		c[2:0] = op;
		c[15:8] = imm;
		c[21:16] = fa;
		c[24] = dest;
		base = low_cnt;
		wr(core_pkg::REG_CMD, c);
		rdc(core_pkg::REG_WORK, {24'h0, ew});
		chk(32'(low_cnt - base), 32'(busy + 1));
		rdc(core_pkg::REG_STATUS, es);
	endtask

	task automatic end_sim;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		err_total++;
		end_sim();
	end

	initial
	begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		err_total = 0;
		num_checks = 0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		// reset state, unmapped and read-only places
		chk({31'h0, rom_rd}, 32'h0);
		chk({24'h0, t0_mode}, 32'h0);
		rdc(core_pkg::REG_WORK, 32'h0);
		rdc(core_pkg::REG_STATUS, 32'h0);
		rdc(8'h20, 32'h0);
		wr(8'h20, 32'hFFFFFFFF);
		wr(core_pkg::REG_TDH, 32'h3F);
		wr(core_pkg::REG_T0MODE, 32'hFF);
		rdc(core_pkg::REG_TDH, 32'h0);
		rdc(core_pkg::REG_T0MODE, 32'h0);
		// subtract across borrow corners
		for (i = 0; i < 6; i++)
		begin
			a = sub_i[i];
			b = sub_w[i];
			r = a - b;
			wr(core_pkg::REG_WORK, {24'h0, b});
			run(core_pkg::OP_IMM_MINUS_WORK, a, 6'h0, 1'b0, 1, r,
				{29'h0, r == 8'h0, a[3:0] >= b[3:0], a >= b});
		end
		// immediate xor keeps carry and nibble flags
		wr(core_pkg::REG_WORK, 32'hF0);
		wr(core_pkg::REG_STATUS, 32'h3);
		run(core_pkg::OP_XOR_IMM, 8'hA5, 6'h0, 1'b0, 1, 8'h55, 32'h3);
		run(core_pkg::OP_XOR_IMM, 8'h55, 6'h0, 1'b0, 1, 8'h00, 32'h7);
		run(core_pkg::OP_XOR_IMM, 8'hFF, 6'h0, 1'b0, 1, 8'hFF, 32'h3);
		// file xor, both destinations, top and bottom file
		wr(core_pkg::REG_FSEL, 32'h3F);
		wr(core_pkg::REG_FDATA, 32'hA5);
		wr(core_pkg::REG_WORK, 32'hF0);
		wr(core_pkg::REG_STATUS, 32'h0);
		run(core_pkg::OP_XOR_FILE, 8'h0F, 6'h3F, 1'b1, 1, 8'hF0, 32'h0);
		rdc(core_pkg::REG_FDATA, 32'h55);
		wr(core_pkg::REG_FSEL, 32'h0);
		wr(core_pkg::REG_FDATA, 32'hF0);
		wr(core_pkg::REG_STATUS, 32'h3);
		run(core_pkg::OP_XOR_FILE, 8'h0F, 6'h00, 1'b0, 1, 8'h00, 32'h7);
		rdc(core_pkg::REG_FDATA, 32'hF0);
		// timer mode load and read back, flags untouched
		wr(core_pkg::REG_WORK, 32'hAA);
		wr(core_pkg::REG_STATUS, 32'h5);
		run(core_pkg::OP_TMODE_LOAD, 8'h00, 6'h0, 1'b0, 1, 8'hAA, 32'h5);
		chk({24'h0, t0_mode}, 32'hAA);
		wr(core_pkg::REG_T0MODE, 32'h11);
		rdc(core_pkg::REG_T0MODE, 32'hAA);
		wr(core_pkg::REG_WORK, 32'h00);
		wr(core_pkg::REG_STATUS, 32'h2);
		run(core_pkg::OP_TMODE_READ, 8'h00, 6'h0, 1'b0, 1, 8'hAA, 32'h2);
		// unused code: one busy cycle, nothing changes, fields read back
		run(core_pkg::OP_NONE_A, 8'h5A, 6'h2A, 1'b1, 1, 8'hAA, 32'h2);
		rdc(core_pkg::REG_CMD, 32'h012A5A06);
		// table reads with pointer extremes
		for (i = 0; i < 3; i++)
		begin
			a = tbl_p[i];
			b = tbl_w[i];
			w = rom_word({a[2:0], b});
			wr(core_pkg::REG_TPH, {24'h0, a});
			wr(core_pkg::REG_WORK, {24'h0, b});
			wr(core_pkg::REG_STATUS, 32'h6);
			run(core_pkg::OP_TABLE_READ, 8'h00, 6'h0, 1'b0, 2, w[7:0], 32'h6);
			chk({21'h0, rom_seen}, {21'h0, a[2:0], b});
			rdc(core_pkg::REG_TDH, {26'h0, w[13:8]});
		end
		end_sim();
	end
endmodule
`default_nettype wire
